/* File: core/ccc_consts.vh */
`ifndef CCC_CONSTS_VH
`define CCC_CONSTS_VH

// Level and bus widths
`define CCC_LW 10
`define CCC_AW 8
`define CCC_DW 32

// Register byte addresses
`define CCC_OFF_CTRL0 8'h94
`define CCC_OFF_CTRL1 8'h98
`define CCC_OFF_CTRL2 8'h9C
`define CCC_OFF_CTRL3 8'hA0
`define CCC_OFF_STAT 8'hA4
`define CCC_OFF_CFG 8'hA8

// Control register fields
`define CCC_CTRL_RST 8'h00
`define CCC_B_ON 7
`define CCC_B_IE 6
`define CCC_IS_HI 5
`define CCC_IS_LO 4
`define CCC_B_BIT3 3
`define CCC_NS_HI 2
`define CCC_NS_LO 0

// Status register fields
`define CCC_ST_RES_LO 0
`define CCC_ST_FLG_LO 4

// Config register fields
`define CCC_CFG_HALF 0
`define CCC_CFG_AMP_LO 1

// Event edge codes
`define CCC_EDGE_ANY 2'h0
`define CCC_EDGE_RSV 2'h1
`define CCC_EDGE_FALL 2'h2
`define CCC_EDGE_RISE 2'h3

// Negative input codes
`define CCC_NEG_D640 3'h0
`define CCC_NEG_D320 3'h1
`define CCC_NEG_D213 3'h2
`define CCC_NEG_D160 3'h3
`define CCC_NEG_BGAP 3'h4
`define CCC_NEG_DAC 3'h5
`define CCC_NEG_PIN 3'h6
`define CCC_NEG_RSV 3'h7

// Reference source codes
`define CCC_REF_AREF 2'h0
`define CCC_REF_AVCC 2'h1
`define CCC_REF_INT 2'h3

// Divider scale factors
`define CCC_MUL10 17'h0000A
`define CCC_MUL100 17'h00064
`define CCC_DIV213 17'h000D5
`define CCC_SH_D640 6
`define CCC_SH_D320 5
`define CCC_SH_D160 4
`define CCC_LVL_MAX 10'h3FF

`endif

/* File: core/ccc_top.v */
// Behaviour
// [RL1] Four channels, own positive, selectable negative
// [RL2] Result high when positive exceeds negative
// [RL3] Sample on I/O clock, optionally halved
// [RL4] One dedicated interrupt request per channel
// [RL5] Edge select: toggle, falling, rising; 01 reserved
// [RL6] Control bit 7 enables the channel
// [RL7] Control bit 6 gates the interrupt request
// [RL8] Event flags serve as conversion start triggers
// [RL9] Channel 1 result can feed timer capture
// [RL10] Amplifier link: amp input, amp clock
// [RL11] Channel 0 bit 3 picks PLL clock
// [RL12] Negative select: four taps, bandgap, DAC
// [RL13] Taps divide the converter-selected reference
// [RL14] Control registers reset to all zeros
// [RL15] Code 110 shared pin; 111 reserved
// [RL16] Capture edge follows capture edge polarity
// [RL17] Flag sets regardless; clears on ack or W1C
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "ccc_consts.vh"

module ccc_top (
  // Clock and reset
  input wire mclk_i,
  input wire srst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`CCC_AW-1:0] paddr_i,
  input wire [`CCC_DW-1:0] pwdata_i,
  output reg [`CCC_DW-1:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Analog levels, digitised
  input wire [4*`CCC_LW-1:0] pos_level_i,
  input wire [3*`CCC_LW-1:0] amp_level_i,
  input wire [`CCC_LW-1:0] shared_negative_pin_i,
  input wire [`CCC_LW-1:0] bandgap_level_i,
  input wire [`CCC_LW-1:0] dac_level_i,
  input wire [`CCC_LW-1:0] ref_aref_level_i,
  input wire [`CCC_LW-1:0] ref_avcc_level_i,
  input wire [`CCC_LW-1:0] ref_int_level_i,
  input wire [1:0] reference_select_i,
  // Sampling strobes
  input wire pll_tick_i,
  input wire [2:0] amp_tick_i,
  // Timer and interrupt controller
  input wire capture_edge_polarity_i,
  input wire [3:0] irq_ack_i,
  // Channel outputs
  output wire [3:0] comparator_result_o,
  output wire [3:0] channel_event_flag_o,
  output wire [3:0] irq_o,
  output wire [3:0] conv_trigger_o,
  output wire capture_source_o,
  output wire capture_trigger_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function [`CCC_LW-1:0] tap_shift;
    input [`CCC_LW-1:0] v;
    input integer sh;
    reg [16:0] p;
    begin
      p = {7'h00, v} * `CCC_MUL10;
      p = p >> sh;
      tap_shift = p[`CCC_LW-1:0];
    end
  endfunction

  function [`CCC_LW-1:0] tap_213;
    input [`CCC_LW-1:0] v;
    reg [16:0] p;
    begin
      p = {7'h00, v} * `CCC_MUL100;
      p = p / `CCC_DIV213;
      tap_213 = p[`CCC_LW-1:0];
    end
  endfunction

  function [`CCC_LW-1:0] lvl;
    input [4*`CCC_LW-1:0] bus;
    input integer idx;
    begin
      lvl = bus[idx*`CCC_LW +: `CCC_LW];
    end
  endfunction

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  reg [7:0] ctrl_q [0:3];
  reg half_cfg_q;
  reg [2:0] amp_link_q;
  reg [3:0] flag_q;
  reg [3:0] result_q;
  reg err_q;

  wire setup = psel_i & ~penable_i;
  wire acc = psel_i & penable_i;
  wire wr_acc = acc & pwrite_i & ~err_q;

  reg [`CCC_DW-1:0] rd_d;
  reg hit_d;
  always @* begin
    rd_d = {`CCC_DW{1'b0}};
    hit_d = 1'b1;
    case (paddr_i)
      `CCC_OFF_CTRL0: rd_d[7:0] = ctrl_q[0];
      `CCC_OFF_CTRL1: rd_d[7:0] = ctrl_q[1];
      `CCC_OFF_CTRL2: rd_d[7:0] = ctrl_q[2];
      `CCC_OFF_CTRL3: rd_d[7:0] = ctrl_q[3];
      `CCC_OFF_STAT: begin
        rd_d[`CCC_ST_RES_LO +: 4] = result_q;
        rd_d[`CCC_ST_FLG_LO +: 4] = flag_q;
      end
      `CCC_OFF_CFG: begin
        rd_d[`CCC_CFG_HALF] = half_cfg_q;
        rd_d[`CCC_CFG_AMP_LO +: 3] = amp_link_q;
      end
      default: hit_d = 1'b0;
    endcase
  end

  // Read data and decode error are captured in the setup cycle
  always @(posedge mclk_i) begin
    if (srst_i) begin
      prdata_o <= {`CCC_DW{1'b0}};
      err_q <= 1'b0;
    end else if (setup) begin
      prdata_o <= pwrite_i ? {`CCC_DW{1'b0}} : rd_d;
      err_q <= ~hit_d;
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = acc & err_q;

  // Bit 3 exists only in channels 0 and 1
  integer k;
  always @(posedge mclk_i) begin
    if (srst_i) begin
      for (k = 0; k < 4; k = k + 1) begin
        ctrl_q[k] <= `CCC_CTRL_RST; // [RL14]
      end
      half_cfg_q <= 1'b0;
      amp_link_q <= 3'h0;
    end else if (wr_acc) begin
      case (paddr_i)
        `CCC_OFF_CTRL0: ctrl_q[0] <= pwdata_i[7:0]; // [RL6] [RL7]
        `CCC_OFF_CTRL1: ctrl_q[1] <= pwdata_i[7:0];
        `CCC_OFF_CTRL2: ctrl_q[2] <= pwdata_i[7:0] & 8'hF7;
        `CCC_OFF_CTRL3: ctrl_q[3] <= pwdata_i[7:0] & 8'hF7;
        `CCC_OFF_CFG: begin
          half_cfg_q <= pwdata_i[`CCC_CFG_HALF];
          amp_link_q <= pwdata_i[`CCC_CFG_AMP_LO +: 3];
        end
        default: ;
      endcase
    end
  end

  wire stat_wr = wr_acc & (paddr_i == `CCC_OFF_STAT);
  wire [3:0] w1c = stat_wr ? pwdata_i[`CCC_ST_FLG_LO +: 4] : 4'h0;

  // ------------------------------------------------------------
  // Sample strobes
  // ------------------------------------------------------------
  reg half_q;
  wire pll_src = ctrl_q[0][`CCC_B_BIT3];
  wire base_tick = pll_src ? pll_tick_i : 1'b1; // [RL11]
  wire io_tick = base_tick & (~half_cfg_q | half_q); // [RL3]

  always @(posedge mclk_i) begin
    if (srst_i) begin
      half_q <= 1'b0;
    end else if (base_tick) begin
      half_q <= ~half_q;
    end
  end

  // ------------------------------------------------------------
  // Negative reference taps
  // ------------------------------------------------------------
  reg [`CCC_LW-1:0] vref;
  always @* begin
    case (reference_select_i) // [RL13]
      `CCC_REF_AVCC: vref = ref_avcc_level_i;
      `CCC_REF_INT: vref = ref_int_level_i;
      default: vref = ref_aref_level_i;
    endcase
  end

  wire [`CCC_LW-1:0] t640 = tap_shift(vref, `CCC_SH_D640);
  wire [`CCC_LW-1:0] t320 = tap_shift(vref, `CCC_SH_D320);
  wire [`CCC_LW-1:0] t213 = tap_213(vref);
  wire [`CCC_LW-1:0] t160 = tap_shift(vref, `CCC_SH_D160);

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------
  wire [3:0] rise;
  wire [3:0] fall;
  wire [3:0] evt;
  reg [3:0] flag_d;
  reg [3:0] flag_prev_q;

  genvar n;
  generate
    for (n = 0; n < 4; n = n + 1) begin : g_ch
      wire [7:0] c = ctrl_q[n];
      wire on = c[`CCC_B_ON];
      wire [1:0] es = c[`CCC_IS_HI:`CCC_IS_LO];
      wire [2:0] ns = c[`CCC_NS_HI:`CCC_NS_LO];
      wire link;
      wire tick;
      wire [`CCC_LW-1:0] pos;
      reg [`CCC_LW-1:0] neg;
      reg above;

      if (n < 3) begin : g_amp
        assign link = amp_link_q[n];
        assign pos = link ? amp_level_i[n*`CCC_LW +: `CCC_LW]
                          : lvl(pos_level_i, n); // [RL10]
        assign tick = link ? amp_tick_i[n] : io_tick; // [RL10]
      end else begin : g_pin
        assign link = 1'b0;
        assign pos = lvl(pos_level_i, n); // [RL1]
        assign tick = io_tick;
      end

      always @* begin
        above = 1'b1;
        case (ns) // [RL12] [RL15]
          `CCC_NEG_D640: neg = t640;
          `CCC_NEG_D320: neg = t320;
          `CCC_NEG_D213: neg = t213;
          `CCC_NEG_D160: neg = t160;
          `CCC_NEG_BGAP: neg = bandgap_level_i;
          `CCC_NEG_DAC: neg = dac_level_i;
          `CCC_NEG_PIN: neg = shared_negative_pin_i;
          default: begin
            neg = `CCC_LVL_MAX;
            above = 1'b0;
          end
        endcase
        above = above & (pos > neg); // [RL2]
      end

      // Disabled channel holds its result low and samples nothing
      always @(posedge mclk_i) begin
        if (srst_i) begin
          result_q[n] <= 1'b0;
        end else if (!on) begin
          result_q[n] <= 1'b0; // [RL6]
        end else if (tick) begin
          result_q[n] <= above; // [RL3]
        end
      end

      reg res_prev_q;
      always @(posedge mclk_i) begin
        if (srst_i) begin
          res_prev_q <= 1'b0;
        end else begin
          res_prev_q <= result_q[n];
        end
      end

      assign rise[n] = on & result_q[n] & ~res_prev_q;
      assign fall[n] = on & ~result_q[n] & res_prev_q;

      reg e;
      always @* begin
        case (es) // [RL5]
          `CCC_EDGE_ANY: e = rise[n] | fall[n];
          `CCC_EDGE_FALL: e = fall[n];
          `CCC_EDGE_RISE: e = rise[n];
          default: e = 1'b0;
        endcase
      end
      assign evt[n] = e;

      // Set wins over a clear in the same cycle
      always @* begin
        flag_d[n] = flag_q[n];
        if (irq_ack_i[n] | w1c[n]) begin
          flag_d[n] = 1'b0; // [RL17]
        end
        if (evt[n]) begin
          flag_d[n] = 1'b1; // [RL17]
        end
      end

      assign irq_o[n] = flag_q[n] & c[`CCC_B_IE]; // [RL4] [RL7]
    end
  endgenerate

  always @(posedge mclk_i) begin
    if (srst_i) begin
      flag_q <= 4'h0;
      flag_prev_q <= 4'h0;
    end else begin
      flag_q <= flag_d;
      flag_prev_q <= flag_q;
    end
  end

  // ------------------------------------------------------------
  // Trigger outputs
  // ------------------------------------------------------------
  assign comparator_result_o = result_q;
  assign channel_event_flag_o = flag_q;
  assign conv_trigger_o = flag_q & ~flag_prev_q; // [RL8]

  wire cap_en = ctrl_q[1][`CCC_B_BIT3];
  assign capture_source_o = cap_en & result_q[1]; // [RL9]
  assign capture_trigger_o = cap_en &
    (capture_edge_polarity_i ? rise[1] : fall[1]); // [RL16]

endmodule // ccc_top

/* File: dv/ccc_top_props.sv */
`timescale 1ns/1ps
// ------------------------------
// Port checks
// ------------------------------
module ccc_top_props (
  // Bus side
  input wire mclk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire pslverr_o,
  input wire [3:0] irq_ack_i,
  input wire capture_edge_polarity_i,
  // Channel side
  input wire [3:0] comparator_result_o,
  input wire [3:0] channel_event_flag_o,
  input wire [3:0] irq_o,
  input wire [3:0] conv_trigger_o,
  input wire capture_source_o,
  input wire capture_trigger_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  wire w1c = psel_i && penable_i && pwrite_i && paddr_i == 8'hA4;
  irq_gate_a:
    assert property ((irq_o & ~channel_event_flag_o) == 4'h0) else $error("irq without flag");
  trig_rise_a:
    assert property (conv_trigger_o == (channel_event_flag_o & ~$past(channel_event_flag_o)))
    else $error("trigger not on flag rise");
  flag_src_a:
    assert property (|(channel_event_flag_o & ~$past(channel_event_flag_o)) |->
      $past(comparator_result_o) != $past(comparator_result_o, 2)) else $error("flag w/o edge");
  flag_clr_a:
    assert property (|($past(channel_event_flag_o) & ~channel_event_flag_o) |->
      $past(|irq_ack_i || w1c || srst_i)) else $error("flag lost");
  rst_clear_a:
    assert property ($past(srst_i) |-> {comparator_result_o, channel_event_flag_o} == 8'h00)
    else $error("not clear after reset");
  cap_src_a:
    assert property (capture_source_o |-> comparator_result_o[1]) else $error("capture src");
  cap_trig_a:
    assert property (capture_trigger_o |-> comparator_result_o[1] !=
      $past(comparator_result_o[1]) && comparator_result_o[1] ==
      capture_edge_polarity_i) else $error("capture edge");
  err_phase_a:
    assert property (pslverr_o |-> psel_i && penable_i) else $error("slverr outside access");
endmodule // ccc_top_props

bind ccc_top ccc_top_props i_ccc_top_props (.mclk_i, .srst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pslverr_o, .irq_ack_i, .capture_edge_polarity_i,
  .comparator_result_o, .channel_event_flag_o, .irq_o, .conv_trigger_o,
  .capture_source_o, .capture_trigger_o);

/* File: dv/ccc_top_tb.sv */
`timescale 1ns/1ps
module ccc_top_tb;
  logic mclk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, rerr;
  logic [7:0] paddr_i = 8'h00, a;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
  logic pready_o, pslverr_o, capture_source_o, capture_trigger_o;
  logic [9:0] p0 = 10'h000, p1 = 10'h000;
  logic [9:0] th[8] = '{10'h064, 10'h0C8, 10'h12C, 10'h190, 10'h1F4, 10'h258, 10'h2BC, 10'h384};
  logic [1:0] rsel = 2'h0;
  logic cpol = 1'b1;
  logic [3:0] irq_ack_i = 4'h0, comparator_result_o, channel_event_flag_o, irq_o;
  logic [3:0] conv_trigger_o;
  int miscompares = 0, checked = 0, k;
  always #25 mclk_i = ~mclk_i;
  ccc_top i_ccc_top (.mclk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pos_level_i({20'h0, p1, p0}),
    .amp_level_i(30'h0), .shared_negative_pin_i(th[6]), .bandgap_level_i(th[4]),
    .dac_level_i(th[5]), .ref_aref_level_i(10'h280), .ref_avcc_level_i(10'h3C0),
    .ref_int_level_i(th[7]), .reference_select_i(rsel), .pll_tick_i(1'b0),
    .amp_tick_i(3'h0), .capture_edge_polarity_i(cpol), .irq_ack_i, .comparator_result_o,
    .channel_event_flag_o, .irq_o, .conv_trigger_o, .capture_source_o,
    .capture_trigger_o);
  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task probe(input logic [9:0] t, input logic e);
    for (int j = 0; j < 2; j++) begin
      p0 <= t + 10'(1 - j);
      repeat (4) @(posedge mclk_i);
      chk("result", 32'(e && j == 0), 32'(comparator_result_o[0]));
    end
  endtask
  task wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    srst_i <= 0;
    for (a = 8'h94; a <= 8'hA8; a += 8'h04) begin
      xfer(0, a, 32'h0);
      chk("reset", 32'h0, rdat);
    end
    xfer(1, 8'h9C, 32'hFF);
    xfer(0, 8'h9C, 32'h0);
    chk("ctrl2", 32'hF7, rdat);
    xfer(0, 8'h00, 32'h0);
    chk("unmapped", 32'h1, 32'(rerr));
    $display("test regs done");
    for (k = 0; k < 8; k++) begin
      xfer(1, 8'h94, 32'h80 | k);
      probe(th[k], k < 7);
    end
    chk("irq_masked", 32'h0, 32'(irq_o[0]));
    rsel <= 2'h1;
    xfer(1, 8'h94, 32'h80);
    probe(10'h096, 1);
    xfer(1, 8'hA8, 32'h1);
    probe(10'h096, 1);
    xfer(1, 8'hA8, 32'h0);
    xfer(1, 8'h94, 32'h0);
    probe(10'h190, 0);
    $display("test compare done");
    for (k = 0; k < 4; k++) begin
      xfer(1, 8'h98, 32'hC8 | (k << 4));
      xfer(1, 8'hA4, 32'hF0);
      cpol <= k[0];
      p1 <= 10'h0C8;
      repeat (4) @(posedge mclk_i);
      chk("rise", 32'(k == 0 || k == 3), 32'(channel_event_flag_o[1]));
      chk("irq", 32'(k == 0 || k == 3), 32'(irq_o[1]));
      chk("cap_src", 32'h1, 32'(capture_source_o));
      irq_ack_i <= 4'h2;
      @(posedge mclk_i);
      irq_ack_i <= 4'h0;
      p1 <= 10'h000;
      repeat (4) @(posedge mclk_i);
      chk("fall", 32'(k == 0 || k == 2), 32'(channel_event_flag_o[1]));
      chk("cap_src_low", 32'h0, 32'(capture_source_o));
    end
    $display("test edges done");
    wrap_up;
  end
endmodule // ccc_top_tb
